// ### verilog/dsp_add_align_defs.svh
// dsp_add_align_defs.svh: offsets, fields and reset values of the
// add and align datapath.
// assumes inclusion by bare name
`ifndef DSP_ADD_ALIGN_DEFS_SVH
`define DSP_ADD_ALIGN_DEFS_SVH

// byte addresses on the register bus
`define CTRL_REG_OFS      8'h00
`define INT_STATUS_OFS    8'h04
`define INT_MASK_OFS      8'h08
`define LAST_RESULT_OFS   8'h0C

// control register fields
`define CTRL_OVF_BIT      20
`define CTRL_CARRY_BIT    13

// interrupt status and mask fields
`define INT_OVF_BIT       0
`define INT_BYTE_POS_BIT  1
`define INT_BITS          2

// reset values
`define CTRL_OVF_RST      1'h0
`define CTRL_CARRY_RST    1'h0
`define INT_RST           2'h0
`define RESULT_RST        32'h00000000

// bus responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### verilog/dsp_add_align_pkg.sv
// dsp_add_align_pkg: types shared by the datapath and its users.
// assumes the pipeline encodes its operation with op_t
package dsp_add_align_pkg;

    // operations carried out by the datapath
    typedef enum logic [2:0] {
        OP_QUAD_BYTE_ADD_WRAP,
        OP_QUAD_BYTE_ADD_SAT,
        OP_WORD_ADD_WITH_CARRY,
        OP_WORD_ADD_SET_CARRY,
        OP_QUAD_BYTE_HALVING_ADD,
        OP_QUAD_BYTE_HALVING_ADD_ROUND,
        OP_SHIFT_APPEND,
        OP_TWO_REG_BYTE_ALIGN
    } op_t;

endpackage

// ### verilog/quad_byte_lanes.sv
// quad_byte_lanes: combinational per-lane unsigned byte adders.
// assumes operands settle in the cycle; no state
`timescale 1ns/1ps
`default_nettype none

module quad_byte_lanes #(
    parameter int LANE_W = 8,
    parameter int LANES  = 4
) (
    input  wire logic [LANE_W*LANES-1:0] i_src_a,
    input  wire logic [LANE_W*LANES-1:0] i_src_b,
    output logic      [LANE_W*LANES-1:0] o_wrap,
    output logic      [LANE_W*LANES-1:0] o_sat,
    output logic      [LANE_W*LANES-1:0] o_half,
    output logic      [LANE_W*LANES-1:0] o_half_round,
    output logic      [LANES-1:0]        o_carry
);

    ////////////////////////////////////////////////////////////////////
    // the bus-side word is fixed at 32 bits
    if (LANE_W * LANES != 32) begin : g_bad_width
        $error("quad_byte_lanes serves only 32-bit words");
    end

    ////////////////////////////////////////////////////////////////////
    // one adder per lane, no carry chain between lanes
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LANE_W:0] sum;
        logic [LANE_W:0] sum_rnd;

        // nine-bit sums; each lane sees only its own bytes
        assign sum = {1'b0, i_src_a[l*LANE_W +: LANE_W]}
                   + {1'b0, i_src_b[l*LANE_W +: LANE_W]}; // [RULE1]
        // max 0x1FE, so +1 never leaves nine bits
        assign sum_rnd = sum + {{LANE_W{1'b0}}, 1'b1};    // [RULE8]

        assign o_carry[l] = sum[LANE_W];                  // [RULE16]
        assign o_wrap[l*LANE_W +: LANE_W] =
            sum[LANE_W-1:0];                              // [RULE2]
        assign o_sat[l*LANE_W +: LANE_W] = sum[LANE_W]
            ? {LANE_W{1'b1}} : sum[LANE_W-1:0];           // [RULE3]
        assign o_half[l*LANE_W +: LANE_W] =
            sum[LANE_W:1];                                // [RULE7]
        assign o_half_round[l*LANE_W +: LANE_W] =
            sum_rnd[LANE_W:1];                            // [RULE8]
    end

endmodule // quad_byte_lanes

`default_nettype wire

// ### verilog/dsp_add_align_datapath.sv
// dsp_add_align_datapath: add, append and align unit, its flags
// and an AXI4-Lite slave.
// assumes at most one op per cycle on one clock;
// decode and register file stay in the pipeline.
//
// Operation
// [RULE1] Quad byte adds add each byte lane of one source to the same lane.
// [RULE2] The wrapping quad byte add keeps each lane sum modulo 256.
// [RULE3] The saturating quad byte add clamps an overflowing lane to 0xFF.
// [RULE4] Both quad byte adds set bit 20 on any lane carry, else keep it.
// [RULE5] Add with carry writes both words plus control bit 13, 32 bits.
// [RULE6] Add with carry sets bit 20 when signed sum bits 32 and 31 differ.
// [RULE7] Halving add writes bits 8..1 of each nine-bit lane sum.
// [RULE8] Rounding halving add adds one to each lane sum, then drops bit 0.
// [RULE9] Both halving adds leave the whole control register untouched.
// [RULE10] Append shifts the target left, filling with low source bits.
// [RULE11] Byte align ORs target << 8*pos with source >> 8*(4-pos).
// [RULE12] The byte position is an unsigned two-bit value from 0 to 3.
// [RULE13] No operation traps; overflow shows only in control flags. Here overflow also sets interrupt status bit 0 and can raise o_irq.
// [RULE14] Add and set carry writes its unsigned carry out into bit 13.
// [RULE15] Byte positions 0 and 2 are undefined; only 1 and 3 are defined.
// [RULE16] Lanes are independent; a lane's overflow is its ninth bit only.
// [RULE17] Overflow is sticky: operations only set it, software clears it.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dsp_add_align_defs.svh"

module dsp_add_align_datapath
    import dsp_add_align_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    // operation from the pipeline
    input  wire logic              i_op_valid,
    input  wire op_t               i_op_code,
    input  wire logic [31:0]       i_src_a,
    input  wire logic [31:0]       i_src_b,
    input  wire logic [4:0]        i_shift_amount,
    input  wire logic [1:0]        i_byte_position,
    // result to the pipeline
    output logic                   o_result_valid,
    output logic      [31:0]       o_result,
    output logic                   o_result_unpredictable,
    output logic                   o_ovf_flag,
    output logic                   o_carry_flag,
    // register bus
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic [2:0]        i_awprot,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic      [1:0]        o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic [2:0]        i_arprot,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic      [31:0]       o_rdata,
    output logic      [1:0]        o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    // interrupt
    output logic                   o_irq
);

    ////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (ADDR_W < 4) begin : g_bad_addr
        $error("address too narrow for the register map");
    end

    ////////////////////////////////////////////////////////////////////
    // declarations
    logic              ctrl_ovf;
    logic              ctrl_carry;
    logic [`INT_BITS-1:0] int_status;
    logic [`INT_BITS-1:0] int_mask;
    logic [31:0]       q_wrap;
    logic [31:0]       q_sat;
    logic [31:0]       q_half;
    logic [31:0]       q_half_round;
    logic [3:0]        q_carry;
    logic [32:0]       sum_carry;
    logic [32:0]       sum_set_carry;
    logic [31:0]       append_mask;
    logic [31:0]       append_word;
    logic [63:0]       align_wide;
    logic [31:0]       next_result;
    logic              next_ovf_set;
    logic              next_carry_wr;
    logic              next_carry_val;
    logic              next_unpredictable;
    logic              wr_go;
    logic              rd_go;
    logic [ADDR_W-1:0] wr_word;
    logic [ADDR_W-1:0] rd_word;
    logic              wr_ctrl;
    logic              wr_status;
    logic              wr_mask;
    logic              wr_hit;
    logic              ovf_clear;
    logic [`INT_BITS-1:0] int_event;
    logic [`INT_BITS-1:0] status_clear;
    logic [31:0]       ctrl_word;

    ////////////////////////////////////////////////////////////////////
    // byte lane adders
    quad_byte_lanes #(
        .LANE_W (8),
        .LANES  (4)
    ) u_lanes (
        .i_src_a      (i_src_a),
        .i_src_b      (i_src_b),
        .o_wrap       (q_wrap),
        .o_sat        (q_sat),
        .o_half       (q_half),
        .o_half_round (q_half_round),
        .o_carry      (q_carry)
    );

    ////////////////////////////////////////////////////////////////////
    // word adders
    // signed 33-bit sum with the stored carry at the bottom
    assign sum_carry = {i_src_a[31], i_src_a}
                     + {i_src_b[31], i_src_b}
                     + {32'h00000000, ctrl_carry};         // [RULE5]
    // unsigned sum whose top bit is the new carry
    assign sum_set_carry = {1'b0, i_src_a} + {1'b0, i_src_b};

    // append mask: shift_amount low bits set
    assign append_mask = (32'h00000001 << i_shift_amount)
                       - 32'h00000001;
    assign append_word = (i_src_b << i_shift_amount)
                       | (i_src_a & append_mask);           // [RULE10]

    // align: top word of {b,a} << 8*pos holds both terms
    assign align_wide = {i_src_b, i_src_a}
                      << {i_byte_position, 3'h0};           // [RULE12]

    ////////////////////////////////////////////////////////////////////
    // operation select; nothing here can trap on operand values
    always_comb begin // [RULE13]
        next_result        = i_src_b;
        next_ovf_set       = 1'b0;
        next_carry_wr      = 1'b0;
        next_carry_val     = 1'b0;
        next_unpredictable = 1'b0;
        unique case (i_op_code)
            OP_QUAD_BYTE_ADD_WRAP: begin
                next_result  = q_wrap;                      // [RULE2]
                next_ovf_set = |q_carry;                    // [RULE4]
            end
            OP_QUAD_BYTE_ADD_SAT: begin
                next_result  = q_sat;                       // [RULE3]
                next_ovf_set = |q_carry;                    // [RULE4]
            end
            OP_WORD_ADD_WITH_CARRY: begin
                next_result  = sum_carry[31:0];             // [RULE5]
                next_ovf_set = sum_carry[32]
                             ^ sum_carry[31];               // [RULE6]
            end
            OP_WORD_ADD_SET_CARRY: begin
                next_result    = sum_set_carry[31:0];
                next_carry_wr  = 1'b1;                      // [RULE14]
                next_carry_val = sum_set_carry[32];         // [RULE14]
            end
            OP_QUAD_BYTE_HALVING_ADD: begin
                next_result = q_half;                       // [RULE9]
            end
            OP_QUAD_BYTE_HALVING_ADD_ROUND: begin
                next_result = q_half_round;                 // [RULE9]
            end
            OP_SHIFT_APPEND: begin
                next_result = append_word;                  // [RULE10]
            end
            OP_TWO_REG_BYTE_ALIGN: begin
                next_result = align_wide[63:32];            // [RULE11]
                // positions 0 and 2 are flagged, value left as formed
                next_unpredictable =
                    ~i_byte_position[0];                    // [RULE15]
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // result register, one cycle after the op
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_result_valid         <= 1'b0;
            o_result               <= `RESULT_RST;
            o_result_unpredictable <= 1'b0;
        end else begin
            o_result_valid <= i_op_valid;
            if (i_op_valid) begin
                o_result               <= next_result;
                o_result_unpredictable <= next_unpredictable;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register bus decode
    // aw and w taken together at one edge
    assign wr_go     = i_awvalid & i_wvalid & ~o_bvalid;
    assign o_awready = wr_go;
    assign o_wready  = wr_go;
    assign rd_go     = i_arvalid & ~o_rvalid;
    assign o_arready = rd_go;

    assign wr_word   = {i_awaddr[ADDR_W-1:2], 2'h0};
    assign rd_word   = {i_araddr[ADDR_W-1:2], 2'h0};
    assign wr_ctrl   = wr_go & (wr_word == ADDR_W'(`CTRL_REG_OFS));
    assign wr_status = wr_go & (wr_word == ADDR_W'(`INT_STATUS_OFS));
    assign wr_mask   = wr_go & (wr_word == ADDR_W'(`INT_MASK_OFS));
    assign wr_hit    = wr_ctrl | wr_status | wr_mask
                     | (wr_word == ADDR_W'(`LAST_RESULT_OFS));

    // software clears the flag by writing zero in byte 2
    assign ovf_clear = wr_ctrl & i_wstrb[`CTRL_OVF_BIT/8]
                     & ~i_wdata[`CTRL_OVF_BIT];

    ////////////////////////////////////////////////////////////////////
    // sticky overflow flag; a set in the clearing cycle wins
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_ovf <= `CTRL_OVF_RST;
        end else if (i_op_valid & next_ovf_set) begin
            ctrl_ovf <= 1'b1;                               // [RULE17]
        end else if (ovf_clear) begin
            ctrl_ovf <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // carry bit; the datapath write beats a software write
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_carry <= `CTRL_CARRY_RST;
        end else if (i_op_valid & next_carry_wr) begin
            ctrl_carry <= next_carry_val;                   // [RULE14]
        end else if (wr_ctrl & i_wstrb[`CTRL_CARRY_BIT/8]) begin
            ctrl_carry <= i_wdata[`CTRL_CARRY_BIT];
        end
    end

    assign o_ovf_flag   = ctrl_ovf;
    assign o_carry_flag = ctrl_carry;

    ////////////////////////////////////////////////////////////////////
    // events: overflow, undefined align position
    assign int_event[`INT_OVF_BIT]      = i_op_valid & next_ovf_set;
    assign int_event[`INT_BYTE_POS_BIT] = i_op_valid
                                        & next_unpredictable;
    assign status_clear = (wr_status & i_wstrb[0])
                        ? i_wdata[`INT_BITS-1:0]
                        : `INT_RST;

    // write one to clear; an event in the same cycle keeps its bit
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            int_status <= `INT_RST;
        end else begin
            int_status <= (int_status & ~status_clear) | int_event;
        end
    end

    // interrupt mask, one enables a status bit
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            int_mask <= `INT_RST;
        end else if (wr_mask & i_wstrb[0]) begin
            int_mask <= i_wdata[`INT_BITS-1:0];
        end
    end

    // level output, combinational from four flops
    assign o_irq = |(int_status & int_mask);

    ////////////////////////////////////////////////////////////////////
    // write response, one cycle after both channels are taken
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_bvalid <= 1'b0;
            o_bresp  <= `RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            // the result register is read only but still mapped
            o_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, one cycle after the address is taken
    always_comb begin
        ctrl_word = 32'h00000000;
        ctrl_word[`CTRL_OVF_BIT]   = ctrl_ovf;
        ctrl_word[`CTRL_CARRY_BIT] = ctrl_carry;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h00000000;
            o_rresp  <= `RESP_OKAY;
        end else if (rd_go) begin
            o_rvalid <= 1'b1;
            o_rresp  <= `RESP_OKAY;
            unique case (rd_word)
                ADDR_W'(`CTRL_REG_OFS):    o_rdata <= ctrl_word;
                ADDR_W'(`INT_STATUS_OFS):
                    o_rdata <= {30'h00000000, int_status};
                ADDR_W'(`INT_MASK_OFS):
                    o_rdata <= {30'h00000000, int_mask};
                ADDR_W'(`LAST_RESULT_OFS): o_rdata <= o_result;
                default: begin
                    // unmapped: zero data with an error answer
                    o_rdata <= 32'h00000000;
                    o_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

endmodule // dsp_add_align_datapath

`default_nettype wire

// ### test/dsp_add_align_assertions.sv
// dsp_add_align_assertions: port checks of the add and align unit.
// assumes a bind onto dsp_add_align_datapath by port name
`timescale 1ns/1ps
`default_nettype none

module dsp_add_align_assertions
    import dsp_add_align_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_op_valid,
    input  wire op_t         i_op_code,
    input  wire logic [31:0] i_src_a,
    input  wire logic [31:0] i_src_b,
    input  wire logic [1:0]  i_byte_position,
    input  wire logic        i_awvalid,
    input  wire logic        i_wvalid,
    input  wire logic        o_result_valid,
    input  wire logic [31:0] o_result,
    input  wire logic        o_result_unpredictable,
    input  wire logic        o_ovf_flag,
    input  wire logic        o_carry_flag
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    ////////////////////////////////////////////////////////////////////////
    // ninth-bit carry per lane
    logic [3:0] lane_cy;
    logic       sw_wr;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            lane_cy[k] = 9'(i_src_a[8*k+:8]) + 9'(i_src_b[8*k+:8]) > 9'h0FF;
        end
    end
    // a bus write may clear flags
    assign sw_wr = i_awvalid && i_wvalid;

    sequence s_take(op_t c);
        i_op_valid && i_op_code == c;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_result_pulse: assert property (i_op_valid |=> o_result_valid)
        else $error("no result valid");
    a_wrap_lanes: assert property (s_take(OP_QUAD_BYTE_ADD_WRAP) |=>
        o_result[7:0] == 8'($past(i_src_a[7:0]) + $past(i_src_b[7:0])) &&
        o_result[31:24] == 8'($past(i_src_a[31:24]) + $past(i_src_b[31:24])))
        else $error("wrap sum wrong");
    a_sat_clamp: assert property (s_take(OP_QUAD_BYTE_ADD_SAT) ##0
        lane_cy[0] |=> o_result[7:0] == 8'hFF)
        else $error("lane not clamped");
    a_lane_ovf: assert property ((s_take(OP_QUAD_BYTE_ADD_WRAP) or
        s_take(OP_QUAD_BYTE_ADD_SAT)) ##0 lane_cy != 4'h0 |=> o_ovf_flag)
        else $error("overflow not set");
    a_carry_add: assert property (s_take(OP_WORD_ADD_WITH_CARRY) |=>
        o_result == $past(i_src_a) + $past(i_src_b) + 32'($past(o_carry_flag)))
        else $error("carry sum wrong");
    a_half_quiet: assert property ((s_take(OP_QUAD_BYTE_HALVING_ADD) or
        s_take(OP_QUAD_BYTE_HALVING_ADD_ROUND)) ##0 !sw_wr |=>
        $stable(o_ovf_flag) && $stable(o_carry_flag))
        else $error("flags touched");
    a_align_mark: assert property (s_take(OP_TWO_REG_BYTE_ALIGN) |=>
        o_result_unpredictable == !$past(i_byte_position[0]))
        else $error("align mark wrong");
    a_ovf_sticky: assert property (o_ovf_flag && !sw_wr |=> o_ovf_flag)
        else $error("overflow cleared");
endmodule // dsp_add_align_assertions

bind dsp_add_align_datapath dsp_add_align_assertions
    i_dsp_add_align_assertions (.*);

`default_nettype wire

// ### test/pipe_model.sv
// pipe_model: issuing side of the pipeline, one op per call.
// assumes tasks are entered just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none

module pipe_model
    import dsp_add_align_pkg::*;
(
    input  wire logic  i_clk,
    output logic       o_op_valid,
    output op_t        o_op_code,
    output logic [31:0] o_src_a,
    output logic [31:0] o_src_b,
    output logic [4:0] o_shift_amount,
    output logic [1:0] o_byte_position
);
    // idle at time zero
    initial begin
        o_op_code = OP_QUAD_BYTE_ADD_WRAP;
        {o_op_valid, o_src_a, o_src_b, o_shift_amount,
         o_byte_position} = 72'h0;
    end

    // gap cycles model a stalled pipeline; the idle o_src_a is inverted
    task automatic issue(input op_t c, input logic [31:0] a, b,
                         input logic [4:0] sa, input logic [1:0] bp,
                         input int gap);
        o_op_valid <= 1'b1;
        o_op_code <= c;
        o_src_a <= a;
        o_src_b <= b;
        o_shift_amount <= sa;
        o_byte_position <= bp;
        @(posedge i_clk);
        if (gap > 0) begin
            o_op_valid <= 1'b0;
            o_src_a <= ~a;
            repeat (gap) @(posedge i_clk);
        end
    endtask

    task automatic stop();
        o_op_valid <= 1'b0;
        @(posedge i_clk);
    endtask
endmodule // pipe_model

`default_nettype wire

// ### test/tb_top.sv
// tb_top: self-checking bench for the add and align datapath.
// assumes pipe_model and the checker compiled alongside
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import dsp_add_align_pkg::*;
;
    logic        i_clk, i_reset, i_op_valid, o_result_valid, o_irq;
    op_t         i_op_code;
    logic [31:0] i_src_a, i_src_b, o_result, i_wdata, o_rdata, d, last;
    logic [4:0]  i_shift_amount;
    logic [1:0]  i_byte_position, o_bresp, o_rresp, r, m_stat;
    logic        o_result_unpredictable, o_ovf_flag, o_carry_flag;
    logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid;
    logic        i_bready, i_arvalid, o_arready, o_rvalid, i_rready;
    logic [7:0]  i_awaddr, i_araddr;
    logic [2:0]  i_awprot, i_arprot;
    logic [3:0]  i_wstrb;
    logic        m_ovf, m_carry, m_unp;
    logic [31:0] q_res[$];
    logic [2:0]  q_fl[$];
    int          bad_count, n_checks;

    dsp_add_align_datapath i_dsp_add_align_datapath (.*);
    pipe_model i_pipe_model (.i_clk(i_clk), .o_op_valid(i_op_valid),
        .o_op_code(i_op_code), .o_src_a(i_src_a), .o_src_b(i_src_b),
        .o_shift_amount(i_shift_amount), .o_byte_position(i_byte_position));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // bus master: holds each channel until its own handshake edge
    // bready and rready stay high; a hang is left to the watchdog
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_awaddr <= a;
        i_wdata <= v;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        do begin
            @(posedge i_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1);
        chk("bresp", 32'h0, {30'h0, o_bresp});
    endtask

    task automatic rd(input logic [7:0] a);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        do begin
            @(posedge i_clk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        d = o_rdata;
        r = o_rresp;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reference behaviour, flags updated as a side effect
    function automatic logic [31:0] model(input op_t c, input logic [31:0] a,
        b, input logic [4:0] sa, input logic [1:0] bp);
        logic [31:0] x;
        logic [32:0] t;
        int s;
        x = 32'h0;
        m_unp = 1'b0;
        for (int k = 0; k < 4; k++) begin
            s = int'(a[8*k+:8]) + int'(b[8*k+:8]);
            if (c == OP_QUAD_BYTE_ADD_WRAP || c == OP_QUAD_BYTE_ADD_SAT) begin
                if (s > 255) {m_ovf, m_stat[0]} = 2'h3;
                x[8*k+:8] = (s > 255 && c == OP_QUAD_BYTE_ADD_SAT) ? 8'hFF : 8'(s);
            end
            if (c == OP_QUAD_BYTE_HALVING_ADD) x[8*k+:8] = 8'(s / 2);
            if (c == OP_QUAD_BYTE_HALVING_ADD_ROUND) x[8*k+:8] = 8'((s + 1) / 2);
        end
        case (c)
            OP_WORD_ADD_WITH_CARRY: begin
                t = {a[31], a} + {b[31], b} + 33'(m_carry);
                if (t[32] != t[31]) {m_ovf, m_stat[0]} = 2'h3;
                x = t[31:0];
            end
            OP_WORD_ADD_SET_CARRY: begin
                t = {1'b0, a} + {1'b0, b};
                m_carry = t[32];
                x = t[31:0];
            end
            OP_SHIFT_APPEND: x = (b << sa) | (a & ((32'h1 << sa) - 32'h1));
            OP_TWO_REG_BYTE_ALIGN: begin
                x = (b << (8 * bp)) | (a >> (32 - 8 * bp));
                m_unp = !bp[0];
                if (!bp[0]) m_stat[1] = 1'b1;
            end
            default: ;
        endcase
        return x;
    endfunction

    task automatic op(input op_t c, input logic [31:0] a, b,
                      input logic [4:0] sa, input logic [1:0] bp, input int g);
        last = model(c, a, b, sa, bp);
        q_res.push_back(last);
        q_fl.push_back({m_unp, m_ovf, m_carry});
        i_pipe_model.issue(c, a, b, sa, bp, g);
    endtask

    // each result pulse against the reference queue
    always @(posedge i_clk) begin
        if (!i_reset && o_result_valid === 1'b1) begin
            chk("queued", 32'h1, 32'(q_res.size() > 0));
            chk("result", q_res.pop_front(), o_result);
            chk("flags", 32'(q_fl.pop_front()), {29'h0, o_result_unpredictable,
                o_ovf_flag, o_carry_flag});
        end
    end

    initial begin
        #100000;
        bad_count++;
        $display("ERROR watchdog expected end seen hang");
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h25;
        {i_awaddr, i_araddr, i_awprot, i_arprot, i_wdata} = 54'h0;
        i_wstrb = 4'hF;
        {m_ovf, m_carry, m_stat} = 4'h0;
        void'($urandom(31322));
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        for (int k = 0; k < 4; k++) begin
            rd(8'(4 * k));
            chk("reset value", 32'h0, d);
        end
        $display("test reset done");
        for (int i = 0; i < 240; i++) begin
            if (i % 60 == 59) begin
                i_pipe_model.stop();
                repeat (2) @(posedge i_clk);
                rd(8'h00);
                chk("ctrl", {11'h0, m_ovf, 6'h0, m_carry, 13'h0}, d);
                wr(8'h00, 32'h0);
                {m_ovf, m_carry} = 2'h0;
            end
            op(op_t'($urandom_range(7)), $urandom | (i % 3 ? 0 : 32'hF0F0F0F0),
               $urandom, 5'($urandom), 2'($urandom), i % 5 ? 0 : 2);
        end
        i_pipe_model.stop();
        repeat (2) @(posedge i_clk);
        chk("pending", 32'h0, 32'(q_res.size()));
        $display("test random ops done");
        wr(8'h08, 32'h1);
        wr(8'h04, 32'h3);
        m_stat = 2'h0;
        chk("irq", 32'h0, 32'(o_irq));
        op(OP_QUAD_BYTE_ADD_SAT, 32'h000000FF, 32'h00000001, 5'h0, 2'h0, 2);
        chk("irq", 32'h1, 32'(o_irq));
        wr(8'h08, 32'h2);
        chk("irq", 32'h0, 32'(o_irq));
        op(OP_TWO_REG_BYTE_ALIGN, 32'h11223344, 32'hAABBCCDD, 5'h0, 2'h2, 2);
        chk("irq", 32'h1, 32'(o_irq));
        rd(8'h04);
        chk("status", {30'h0, m_stat}, d);
        $display("test interrupt done");
        rd(8'h10);
        chk("unmapped", 32'h2, {30'h0, r});
        chk("unmapped data", 32'h0, d);
        wr(8'h0C, 32'hFFFFFFFF);
        rd(8'h0C);
        chk("last result", last, d);
        $display("test bus map done");
        conclude();
    end
endmodule // tb_top

`default_nettype wire
